/* File: rtl/usb_flag_regs_pkg.sv */
// Constants and carrier types for the interface-engine flag register block
package usb_flag_regs_pkg;
  localparam logic [7:0] OFF_DEV_ADDR = 8'h08;
  localparam logic [7:0] OFF_OTG_CONTROL = 8'h10;
  localparam logic [7:0] OFF_OTG_STATUS = 8'h14;
  localparam logic [7:0] OFF_SERIAL_LINE_CONTROL = 8'h18;
  localparam logic [7:0] OFF_LINE_EVENT_FLAGS = 8'h1c;
  localparam logic [7:0] OFF_FLAG_STICKINESS = 8'h20;
  localparam logic [7:0] OFF_FLAG_PORT_MASKS = 8'h24;
  localparam logic [7:0] OFF_FRAME_COUNTER = 8'h28;
  localparam logic [7:0] OFF_LAST_PACKET_ID = 8'h2c;
  localparam logic [7:0] OFF_LAST_ENDPOINT = 8'h30;
  localparam logic [7:0] OFF_ENDPOINT_MARKING = 8'h34;
  localparam logic [7:0] OFF_OTG_STATUS_MASK = 8'h38;

  // Serial line control field positions
  localparam int SER_FSLS = 0;
  localparam int SER_TXEN_N = 1;
  localparam int SER_TXDATA = 2;
  localparam int SER_TXSE0 = 3;
  localparam int SER_RXDP = 4;
  localparam int SER_RXDM = 5;
  localparam int SER_RXRCV = 6;
  localparam logic [3:0] SER_RW_MASK = 4'hf;
  localparam logic [3:0] SER_RESET = 4'h2;

  // Line event flag positions
  localparam int FLG_RXERR = 0;
  localparam int FLG_RXACT = 1;
  localparam int FLG_CRC16 = 2;
  localparam int FLG_J = 3;
  localparam int FLG_K = 4;
  localparam int FLG_SE0 = 5;
  localparam int FLG_TOKEN = 6;
  localparam int NUM_FLAGS = 7;

  // Line state codes
  localparam logic [1:0] LS_SE0 = 2'h0;
  localparam logic [1:0] LS_J = 2'h1;
  localparam logic [1:0] LS_K = 2'h2;

  localparam logic [7:0] OTG_CTRL_MASK = 8'hdf;
  localparam logic [4:0] EP_MARK_BIT = 5'h10;
  localparam int EP_VALID_BIT = 4;

  typedef struct packed {
    logic bvalid;
    logic idgnd;
    logic hostdis;
    logic vbusvld;
    logic sessvld;
    logic sessend;
  } otg_sense_s;

  typedef struct packed {
    logic rxrcv;
    logic rxdm;
    logic rxdp;
    logic rxactive;
    logic rxerror;
    logic [1:0] linestate;
  } line_sense_s;

  typedef struct packed {
    logic extvbus_ind;
    logic extvbus_drv;
    logic chrgvbus;
    logic dischrgvbus;
    logic dmpulldown;
    logic dppulldown;
    logic idpullup;
    logic txse0;
    logic txdata;
    logic txenable_n;
    logic fslsserial;
  } xcvr_ctrl_s;
endpackage

/* File: rtl/usb_flag_regs.sv */
// Register-controlled flag, on-the-go and serial line logic of the USB interface engine
//
// Summary of operation
// R1: OTG control bits drive transceiver control outputs
// R2: OTG status reads live synchronised session inputs
// R3: Serial control reports receive levels read-only
// R4: SE0 force, transmit data, serial mode bits
// R5: Transmit enable bit resets one, active low
// R6: Flag 6 on good token to our address
// R7: Flags 5,4,3 on SE0, K, J linestate
// R8: Flag 2 on data CRC16 failure
// R9: Flags 1,0 follow rx active and error
// R10: Non-sticky flags 6 and 2 clear when next packet starts
// R11: Sticky flags hold until written one
// R12: Non-sticky flags 5,4,3,1,0 simply track their source
// R13: Four masks OR flags onto four ports
// R14: Eleven bit frame counter, read-write, resets zero
// R15: Capture last received packet identifier
// R16: Capture last endpoint with valid bit
// R17: Marked endpoints presented ORed with 0x10
// R18: Only packets to device address pass on
// R19: Reserved bits read zero, zero writes harmless
// R20: Otg_status_mask register full read-write
`timescale 1ns/1ns
module usb_flag_regs
  import usb_flag_regs_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DEV_ADDR_W = 7,
  parameter int FRAME_W = 11
) (
  input wire logic MCLK_I,
  input wire logic RST_I,
  // Register port, one word per access
  input wire logic [ADDR_W-1:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [31:0] REG_WDATA_I,
  output logic [31:0] REG_RDATA_O,
  output logic REG_ACK_O,
  // Transceiver sense pins, asynchronous
  input wire logic UTMI_BVALID_I,
  input wire logic UTMI_IDGND_I,
  input wire logic UTMI_HOSTDIS_I,
  input wire logic UTMI_VBUSVLD_I,
  input wire logic UTMI_SESSVLD_I,
  input wire logic UTMI_SESSEND_I,
  input wire logic UTMI_RXRCV_I,
  input wire logic UTMI_RXDM_I,
  input wire logic UTMI_RXDP_I,
  input wire logic UTMI_RXACTIVE_I,
  input wire logic UTMI_RXERROR_I,
  input wire logic [1:0] UTMI_LINESTATE_I,
  // Packet decoder results, same clock
  input wire logic PKT_START_I,
  input wire logic PID_VALID_I,
  input wire logic [3:0] PID_I,
  input wire logic TOKEN_VALID_I,
  input wire logic TOKEN_CHECK_OK_I,
  input wire logic [DEV_ADDR_W-1:0] TOKEN_ADDR_I,
  input wire logic [3:0] TOKEN_EP_I,
  input wire logic [FRAME_W-1:0] SOF_FRAME_I,
  input wire logic SOF_VALID_I,
  input wire logic DATA_CRC16_FAIL_I,
  // Transceiver control
  output logic UTMI_IDPULLUP_O,
  output logic UTMI_DPPULLDOWN_O,
  output logic UTMI_DMPULLDOWN_O,
  output logic UTMI_DISCHRGVBUS_O,
  output logic UTMI_CHRGVBUS_O,
  output logic EXTERNAL_VBUS_DRIVE_O,
  output logic EXTERNAL_VBUS_INDICATOR_O,
  output logic UTMI_TXSE0_O,
  output logic UTMI_TXDATA_O,
  output logic UTMI_TXENABLE_N_O,
  output logic UTMI_FSLSSERIAL_O,
  // Flag ports and endpoint receive port
  output logic FLAG_PORT_N_O,
  output logic FLAG_PORT_O_O,
  output logic FLAG_PORT_P_O,
  output logic FLAG_PORT_Q_O,
  output logic [4:0] RX_EP_O,
  output logic RX_EP_VALID_O,
  output logic TOKEN_ACCEPT_O
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    otg_sense_s otg_sync1;
    otg_sense_s otg_sync2;
    line_sense_s line_sync1;
    line_sense_s line_sync2;
    xcvr_ctrl_s ctrl;
    logic [DEV_ADDR_W-1:0] dev_addr;
    logic [NUM_FLAGS-1:0] flags;
    logic [NUM_FLAGS-1:0] sticky;
    logic [31:0] port_masks;
    logic [FRAME_W-1:0] frame;
    logic [3:0] last_pid;
    logic [3:0] last_ep;
    logic ep_valid;
    logic [15:0] ep_mark;
    logic [31:0] otg_status_mask;
    logic [3:0] port_out;
    logic [4:0] rx_ep;
    logic rx_ep_valid;
    logic token_accept;
    logic [31:0] rdata;
    logic ack;
  } state_s;

  state_s state_reg;
  state_s state_next;

  localparam state_s STATE_RESET = '{
    ctrl: '{txenable_n: SER_RESET[SER_TXEN_N], default: 1'b0},
    default: '0
  };

  function automatic logic mask_or(input logic [7:0] mask, input logic [NUM_FLAGS-1:0] f);
    mask_or = |(mask[NUM_FLAGS-1:0] & f);
  endfunction

  function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    is_reg = (a == ADDR_W'(off));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic [NUM_FLAGS-1:0] flag_src;
  logic [NUM_FLAGS-1:0] flag_event;
  logic [NUM_FLAGS-1:0] flag_clear;
  logic token_ok;
  logic wr_flags;

  always_comb begin
    state_next = state_reg;
    flag_src = '0;
    flag_event = '0;
    flag_clear = '0;
    token_ok = 1'b0;
    wr_flags = 1'b0;

    // Two-stage synchronisers; only stage two is read below
    state_next.otg_sync1 = '{UTMI_BVALID_I, UTMI_IDGND_I, UTMI_HOSTDIS_I,
                             UTMI_VBUSVLD_I, UTMI_SESSVLD_I, UTMI_SESSEND_I};
    state_next.otg_sync2 = state_reg.otg_sync1;
    state_next.line_sync1 = '{UTMI_RXRCV_I, UTMI_RXDM_I, UTMI_RXDP_I,
                              UTMI_RXACTIVE_I, UTMI_RXERROR_I, UTMI_LINESTATE_I};
    state_next.line_sync2 = state_reg.line_sync1;

    // Token must pass checks and carry our address
    token_ok = TOKEN_VALID_I && TOKEN_CHECK_OK_I &&
               (TOKEN_ADDR_I == state_reg.dev_addr); // [R6] [R18]
    state_next.token_accept = token_ok; // [R18]

    // Event-style sources
    flag_event[FLG_TOKEN] = token_ok; // [R6]
    flag_event[FLG_CRC16] = DATA_CRC16_FAIL_I; // [R8]
    // Level-style sources
    flag_src[FLG_SE0] = (state_reg.line_sync2.linestate == LS_SE0); // [R7]
    flag_src[FLG_K] = (state_reg.line_sync2.linestate == LS_K); // [R7]
    flag_src[FLG_J] = (state_reg.line_sync2.linestate == LS_J); // [R7]
    flag_src[FLG_RXACT] = state_reg.line_sync2.rxactive; // [R9]
    flag_src[FLG_RXERR] = state_reg.line_sync2.rxerror; // [R9]

    wr_flags = REG_WR_I && is_reg(REG_ADDR_I, OFF_LINE_EVENT_FLAGS);
    if (wr_flags) begin
      flag_clear = REG_WDATA_I[NUM_FLAGS-1:0]; // [R11] [R19]
    end

    for (int i = 0; i < NUM_FLAGS; i++) begin
      if (state_reg.sticky[i]) begin
        // Set beats a clear written in the same cycle
        if (flag_event[i] || flag_src[i]) begin
          state_next.flags[i] = 1'b1; // [R11]
        end else if (flag_clear[i]) begin
          state_next.flags[i] = 1'b0; // [R11]
        end
      end else if (i == FLG_TOKEN || i == FLG_CRC16) begin
        if (flag_event[i]) begin
          state_next.flags[i] = 1'b1; // [R6] [R8]
        end else if (PKT_START_I || flag_clear[i]) begin
          state_next.flags[i] = 1'b0; // [R10]
        end
      end else begin
        state_next.flags[i] = flag_src[i]; // [R12]
      end
    end

    // Captures from the packet decoder
    if (PID_VALID_I) begin
      state_next.last_pid = PID_I; // [R15]
    end
    if (token_ok) begin
      state_next.last_ep = TOKEN_EP_I; // [R16]
      state_next.ep_valid = 1'b1; // [R16]
      state_next.rx_ep = {1'b0, TOKEN_EP_I} |
                         (state_reg.ep_mark[TOKEN_EP_I] ? EP_MARK_BIT : 5'h0_0); // [R17]
    end
    state_next.rx_ep_valid = token_ok; // [R17]
    if (SOF_VALID_I) begin
      state_next.frame = SOF_FRAME_I; // [R14]
    end

    // Register writes; software wins over a same-cycle frame update
    if (REG_WR_I) begin
      unique case (1'b1)
        is_reg(REG_ADDR_I, OFF_DEV_ADDR): begin
          state_next.dev_addr = REG_WDATA_I[DEV_ADDR_W-1:0]; // [R18]
        end
        is_reg(REG_ADDR_I, OFF_OTG_CONTROL): begin
          state_next.ctrl.extvbus_ind = REG_WDATA_I[7]; // [R1]
          state_next.ctrl.extvbus_drv = REG_WDATA_I[6]; // [R1]
          state_next.ctrl.chrgvbus = REG_WDATA_I[4]; // [R1]
          state_next.ctrl.dischrgvbus = REG_WDATA_I[3]; // [R1]
          state_next.ctrl.dmpulldown = REG_WDATA_I[2]; // [R1]
          state_next.ctrl.dppulldown = REG_WDATA_I[1]; // [R1]
          state_next.ctrl.idpullup = REG_WDATA_I[0]; // [R1]
        end
        is_reg(REG_ADDR_I, OFF_SERIAL_LINE_CONTROL): begin
          state_next.ctrl.txse0 = REG_WDATA_I[SER_TXSE0]; // [R4]
          state_next.ctrl.txdata = REG_WDATA_I[SER_TXDATA]; // [R4]
          state_next.ctrl.txenable_n = REG_WDATA_I[SER_TXEN_N]; // [R5]
          state_next.ctrl.fslsserial = REG_WDATA_I[SER_FSLS]; // [R4]
        end
        is_reg(REG_ADDR_I, OFF_FLAG_STICKINESS): begin
          state_next.sticky = REG_WDATA_I[NUM_FLAGS-1:0]; // [R11]
        end
        is_reg(REG_ADDR_I, OFF_FLAG_PORT_MASKS): begin
          state_next.port_masks = REG_WDATA_I; // [R13]
        end
        is_reg(REG_ADDR_I, OFF_FRAME_COUNTER): begin
          state_next.frame = REG_WDATA_I[FRAME_W-1:0]; // [R14]
        end
        is_reg(REG_ADDR_I, OFF_ENDPOINT_MARKING): begin
          state_next.ep_mark = REG_WDATA_I[15:0]; // [R17]
        end
        is_reg(REG_ADDR_I, OFF_OTG_STATUS_MASK): begin
          state_next.otg_status_mask = REG_WDATA_I; // [R20]
        end
        default: begin
          // Read-only, unmapped or line event flags (cleared above): nothing stored here
        end
      endcase
    end

    // Ports see the flags as they will stand next cycle, so no extra lag
    state_next.port_out[0] = mask_or(state_next.port_masks[7:0], state_next.flags); // [R13]
    state_next.port_out[1] = mask_or(state_next.port_masks[15:8], state_next.flags); // [R13]
    state_next.port_out[2] = mask_or(state_next.port_masks[23:16], state_next.flags); // [R13]
    state_next.port_out[3] = mask_or(state_next.port_masks[31:24], state_next.flags); // [R13]

    // Read data, registered; unmapped reads return zero
    state_next.ack = REG_RD_I || REG_WR_I;
    state_next.rdata = '0; // [R19]
    if (REG_RD_I) begin
      unique case (1'b1)
        is_reg(REG_ADDR_I, OFF_DEV_ADDR): begin
          state_next.rdata[DEV_ADDR_W-1:0] = state_reg.dev_addr;
        end
        is_reg(REG_ADDR_I, OFF_OTG_CONTROL): begin
          state_next.rdata[7:0] = {state_reg.ctrl.extvbus_ind, state_reg.ctrl.extvbus_drv,
                                   1'b0, state_reg.ctrl.chrgvbus,
                                   state_reg.ctrl.dischrgvbus, state_reg.ctrl.dmpulldown,
                                   state_reg.ctrl.dppulldown, state_reg.ctrl.idpullup}
                                  & OTG_CTRL_MASK; // [R1] [R19]
        end
        is_reg(REG_ADDR_I, OFF_OTG_STATUS): begin
          state_next.rdata[5:0] = state_reg.otg_sync2; // [R2]
        end
        is_reg(REG_ADDR_I, OFF_SERIAL_LINE_CONTROL): begin
          state_next.rdata[SER_RXRCV] = state_reg.line_sync2.rxrcv; // [R3]
          state_next.rdata[SER_RXDM] = state_reg.line_sync2.rxdm; // [R3]
          state_next.rdata[SER_RXDP] = state_reg.line_sync2.rxdp; // [R3]
          state_next.rdata[3:0] = {state_reg.ctrl.txse0, state_reg.ctrl.txdata,
                                   state_reg.ctrl.txenable_n, state_reg.ctrl.fslsserial}
                                  & SER_RW_MASK; // [R4] [R5]
        end
        is_reg(REG_ADDR_I, OFF_LINE_EVENT_FLAGS): begin
          state_next.rdata[NUM_FLAGS-1:0] = state_reg.flags;
        end
        is_reg(REG_ADDR_I, OFF_FLAG_STICKINESS): begin
          state_next.rdata[NUM_FLAGS-1:0] = state_reg.sticky;
        end
        is_reg(REG_ADDR_I, OFF_FLAG_PORT_MASKS): begin
          state_next.rdata = state_reg.port_masks;
        end
        is_reg(REG_ADDR_I, OFF_FRAME_COUNTER): begin
          state_next.rdata[FRAME_W-1:0] = state_reg.frame; // [R14]
        end
        is_reg(REG_ADDR_I, OFF_LAST_PACKET_ID): begin
          state_next.rdata[3:0] = state_reg.last_pid; // [R15]
        end
        is_reg(REG_ADDR_I, OFF_LAST_ENDPOINT): begin
          state_next.rdata[EP_VALID_BIT:0] = {state_reg.ep_valid, state_reg.last_ep}; // [R16]
        end
        is_reg(REG_ADDR_I, OFF_ENDPOINT_MARKING): begin
          state_next.rdata[15:0] = state_reg.ep_mark;
        end
        is_reg(REG_ADDR_I, OFF_OTG_STATUS_MASK): begin
          state_next.rdata = state_reg.otg_status_mask; // [R20]
        end
        default: begin
          state_next.rdata = '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flops

  assign REG_RDATA_O = state_reg.rdata;
  assign REG_ACK_O = state_reg.ack;
  assign UTMI_IDPULLUP_O = state_reg.ctrl.idpullup; // [R1]
  assign UTMI_DPPULLDOWN_O = state_reg.ctrl.dppulldown;
  assign UTMI_DMPULLDOWN_O = state_reg.ctrl.dmpulldown;
  assign UTMI_DISCHRGVBUS_O = state_reg.ctrl.dischrgvbus;
  assign UTMI_CHRGVBUS_O = state_reg.ctrl.chrgvbus;
  assign EXTERNAL_VBUS_DRIVE_O = state_reg.ctrl.extvbus_drv;
  assign EXTERNAL_VBUS_INDICATOR_O = state_reg.ctrl.extvbus_ind;
  assign UTMI_TXSE0_O = state_reg.ctrl.txse0; // [R4]
  assign UTMI_TXDATA_O = state_reg.ctrl.txdata;
  assign UTMI_TXENABLE_N_O = state_reg.ctrl.txenable_n; // [R5]
  assign UTMI_FSLSSERIAL_O = state_reg.ctrl.fslsserial;
  assign FLAG_PORT_N_O = state_reg.port_out[0];
  assign FLAG_PORT_O_O = state_reg.port_out[1];
  assign FLAG_PORT_P_O = state_reg.port_out[2];
  assign FLAG_PORT_Q_O = state_reg.port_out[3];
  assign RX_EP_O = state_reg.rx_ep;
  assign RX_EP_VALID_O = state_reg.rx_ep_valid;
  assign TOKEN_ACCEPT_O = state_reg.token_accept;

endmodule

/* File: sim/usb_flag_regs_properties.sv */
// Port-level checks for the flag register block
`timescale 1ns/1ns
module usb_flag_regs_properties
  import usb_flag_regs_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic MCLK_I,
  input wire logic RST_I,
  input wire logic [ADDR_W-1:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic [31:0] REG_RDATA_O,
  input wire logic REG_ACK_O,
  input wire logic TOKEN_VALID_I,
  input wire logic TOKEN_CHECK_OK_I,
  input wire logic [3:0] TOKEN_EP_I,
  input wire logic UTMI_IDPULLUP_O,
  input wire logic EXTERNAL_VBUS_DRIVE_O,
  input wire logic UTMI_TXENABLE_N_O,
  input wire logic UTMI_TXSE0_O,
  input wire logic FLAG_PORT_N_O,
  input wire logic FLAG_PORT_O_O,
  input wire logic FLAG_PORT_P_O,
  input wire logic FLAG_PORT_Q_O,
  input wire logic [4:0] RX_EP_O,
  input wire logic RX_EP_VALID_O,
  input wire logic TOKEN_ACCEPT_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  sequence wr_at(a);
    REG_WR_I && REG_ADDR_I == a;
  endsequence
  // Mask cleared, then left alone for one more cycle
  sequence masks_zero;
    REG_WR_I && REG_ADDR_I == OFF_FLAG_PORT_MASKS && REG_WDATA_I == 32'h0000_0000
    ##1 !(REG_WR_I && REG_ADDR_I == OFF_FLAG_PORT_MASKS);
  endsequence
  a_strobe_gets_ack: assert property ((REG_WR_I || REG_RD_I) |=> REG_ACK_O)
    else $error("strobe not acknowledged");
  a_idle_rdata_zero: assert property (!REG_ACK_O |-> REG_RDATA_O == 32'h0000_0000)
    else $error("read data not zero outside ack");
  a_otg_bits_drive: assert property (wr_at(OFF_OTG_CONTROL) |=>
    UTMI_IDPULLUP_O == $past(REG_WDATA_I[0]) && EXTERNAL_VBUS_DRIVE_O == $past(REG_WDATA_I[6]))
    else $error("otg control output wrong");
  a_serial_bits_drive: assert property (wr_at(OFF_SERIAL_LINE_CONTROL) |=>
    UTMI_TXENABLE_N_O == $past(REG_WDATA_I[SER_TXEN_N])
    && UTMI_TXSE0_O == $past(REG_WDATA_I[SER_TXSE0]))
    else $error("serial control output wrong");
  a_bad_token_drop: assert property (TOKEN_VALID_I && !TOKEN_CHECK_OK_I |=>
    !TOKEN_ACCEPT_O && !RX_EP_VALID_O)
    else $error("bad token accepted");
  a_accept_has_cause: assert property (TOKEN_ACCEPT_O |->
    RX_EP_VALID_O && $past(TOKEN_VALID_I && TOKEN_CHECK_OK_I))
    else $error("accept without good token");
  a_ep_copy_low: assert property (RX_EP_VALID_O |-> RX_EP_O[3:0] == $past(TOKEN_EP_I))
    else $error("endpoint number not copied");
  a_ep_port_holds: assert property (!RX_EP_VALID_O |-> $stable(RX_EP_O))
    else $error("endpoint port moved without token");
  a_masks_cleared: assert property (masks_zero |=>
    {FLAG_PORT_N_O, FLAG_PORT_O_O, FLAG_PORT_P_O, FLAG_PORT_Q_O} == 4'h0)
    else $error("flag port high with empty mask");
endmodule

bind usb_flag_regs usb_flag_regs_properties #(.ADDR_W(ADDR_W)) i_usb_flag_regs_properties (
  .MCLK_I, .RST_I, .REG_ADDR_I, .REG_WR_I, .REG_RD_I, .REG_WDATA_I, .REG_RDATA_O, .REG_ACK_O,
  .TOKEN_VALID_I, .TOKEN_CHECK_OK_I, .TOKEN_EP_I, .UTMI_IDPULLUP_O, .EXTERNAL_VBUS_DRIVE_O,
  .UTMI_TXENABLE_N_O, .UTMI_TXSE0_O, .FLAG_PORT_N_O, .FLAG_PORT_O_O, .FLAG_PORT_P_O,
  .FLAG_PORT_Q_O, .RX_EP_O, .RX_EP_VALID_O, .TOKEN_ACCEPT_O);

/* File: sim/utmi_xcvr_model.sv */
// Behavioural transceiver that drives the sense pins
`timescale 1ns/1ns
module utmi_xcvr_model
  import usb_flag_regs_pkg::*;
(
  input wire logic clk_i,
  input wire otg_sense_s otg_i,
  input wire line_sense_s line_i,
  input wire logic txse0_i,
  output otg_sense_s otg_o,
  output line_sense_s line_o
);
  line_sense_s line_v;
  initial begin
    otg_o = '0;
    line_o = '0;
  end
  // Pins move off the clock grid, as an asynchronous phy would
  always @(negedge clk_i) begin
    #3;
    otg_o <= otg_i;
    line_v = line_i;
    // Forced SE0 from the block shows on the line
    if (txse0_i) begin
      line_v.linestate = LS_SE0;
    end
    line_o <= line_v;
  end
endmodule

/* File: sim/tb_usb_flag_regs.sv */
// Self-checking bench for the flag register block
`timescale 1ns/1ns
module tb_usb_flag_regs;
  import usb_flag_regs_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] q;} row_s;
  logic MCLK_I = 0, RST_I = 1, REG_WR_I = 0, REG_RD_I = 0, REG_ACK_O;
  logic [7:0] REG_ADDR_I = 0;
  logic [31:0] REG_WDATA_I = 0, REG_RDATA_O, q;
  logic PKT_START_I = 0, PID_VALID_I = 0, TOKEN_VALID_I = 0, TOKEN_CHECK_OK_I = 0;
  logic SOF_VALID_I = 0, DATA_CRC16_FAIL_I = 0, RX_EP_VALID_O, TOKEN_ACCEPT_O;
  logic [3:0] PID_I = 0, TOKEN_EP_I = 0, fp;
  logic [6:0] TOKEN_ADDR_I = 0;
  logic [10:0] SOF_FRAME_I = 0;
  logic [4:0] RX_EP_O;
  otg_sense_s otg_pins = '0, otg_w;
  line_sense_s line_pins = '0, line_w;
  xcvr_ctrl_s ctl;
  int fail_count = 0, comparisons = 0, i;
  row_s rows[10] = '{
    '{OFF_OTG_CONTROL, 32'hffff_ffff, 32'h0000_00df},
    '{OFF_SERIAL_LINE_CONTROL, 32'hffff_ffff, 32'h0000_000f},
    '{OFF_FLAG_STICKINESS, 32'hffff_ffff, 32'h0000_007f},
    '{OFF_FLAG_PORT_MASKS, 32'hffff_ffff, 32'hffff_ffff},
    '{OFF_FRAME_COUNTER, 32'hffff_ffff, 32'h0000_07ff},
    '{OFF_ENDPOINT_MARKING, 32'hffff_ffff, 32'h0000_ffff},
    '{OFF_OTG_STATUS_MASK, 32'ha5a5_5a5a, 32'ha5a5_5a5a},
    '{OFF_DEV_ADDR, 32'hffff_ffff, 32'h0000_007f},
    '{OFF_LAST_PACKET_ID, 32'hffff_ffff, 32'h0000_0000},
    '{8'h40, 32'hffff_ffff, 32'h0000_0000}};
  logic [1:0] ls_codes[3] = '{LS_SE0, LS_J, LS_K};
  logic [2:0] ls_flags[3] = '{3'h4, 3'h1, 3'h2};

  always #5 MCLK_I = ~MCLK_I;

  utmi_xcvr_model i_utmi_xcvr_model (.clk_i(MCLK_I), .otg_i(otg_pins), .line_i(line_pins),
    .txse0_i(ctl.txse0), .otg_o(otg_w), .line_o(line_w));
  usb_flag_regs i_usb_flag_regs (.MCLK_I(MCLK_I), .RST_I(RST_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_WDATA_I(REG_WDATA_I),
    .REG_RDATA_O(REG_RDATA_O), .REG_ACK_O(REG_ACK_O), .UTMI_BVALID_I(otg_w.bvalid),
    .UTMI_IDGND_I(otg_w.idgnd), .UTMI_HOSTDIS_I(otg_w.hostdis), .UTMI_VBUSVLD_I(otg_w.vbusvld),
    .UTMI_SESSVLD_I(otg_w.sessvld), .UTMI_SESSEND_I(otg_w.sessend), .UTMI_RXRCV_I(line_w.rxrcv),
    .UTMI_RXDM_I(line_w.rxdm), .UTMI_RXDP_I(line_w.rxdp), .UTMI_RXACTIVE_I(line_w.rxactive),
    .UTMI_RXERROR_I(line_w.rxerror), .UTMI_LINESTATE_I(line_w.linestate),
    .PKT_START_I(PKT_START_I), .PID_VALID_I(PID_VALID_I), .PID_I(PID_I),
    .TOKEN_VALID_I(TOKEN_VALID_I), .TOKEN_CHECK_OK_I(TOKEN_CHECK_OK_I),
    .TOKEN_ADDR_I(TOKEN_ADDR_I), .TOKEN_EP_I(TOKEN_EP_I), .SOF_FRAME_I(SOF_FRAME_I),
    .SOF_VALID_I(SOF_VALID_I), .DATA_CRC16_FAIL_I(DATA_CRC16_FAIL_I),
    .UTMI_IDPULLUP_O(ctl.idpullup), .UTMI_DPPULLDOWN_O(ctl.dppulldown),
    .UTMI_DMPULLDOWN_O(ctl.dmpulldown), .UTMI_DISCHRGVBUS_O(ctl.dischrgvbus),
    .UTMI_CHRGVBUS_O(ctl.chrgvbus), .EXTERNAL_VBUS_DRIVE_O(ctl.extvbus_drv),
    .EXTERNAL_VBUS_INDICATOR_O(ctl.extvbus_ind), .UTMI_TXSE0_O(ctl.txse0),
    .UTMI_TXDATA_O(ctl.txdata), .UTMI_TXENABLE_N_O(ctl.txenable_n),
    .UTMI_FSLSSERIAL_O(ctl.fslsserial), .FLAG_PORT_N_O(fp[3]), .FLAG_PORT_O_O(fp[2]),
    .FLAG_PORT_P_O(fp[1]), .FLAG_PORT_Q_O(fp[0]), .RX_EP_O(RX_EP_O),
    .RX_EP_VALID_O(RX_EP_VALID_O), .TOKEN_ACCEPT_O(TOKEN_ACCEPT_O));

  ////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One strobe cycle, then a bounded wait for the ack pulse
  task automatic rw(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(negedge MCLK_I);
    REG_ADDR_I = a;
    REG_WR_I = w;
    REG_RD_I = !w;
    REG_WDATA_I = d;
    @(negedge MCLK_I);
    REG_WR_I = 0;
    REG_RD_I = 0;
    for (n = 0; n < 4 && REG_ACK_O !== 1'b1; n++) @(negedge MCLK_I);
    if (n == 4) begin
      fail_count++;
      $display("Error at %0t: no acknowledge", $time);
      test_done();
    end
    q = REG_RDATA_O;
  endtask
  task automatic pulse(ref logic s);
    @(negedge MCLK_I);
    s = 1;
    @(negedge MCLK_I);
    s = 0;
  endtask
  task automatic tok(input logic [6:0] a, input logic [3:0] ep, input logic ok);
    @(negedge MCLK_I);
    TOKEN_ADDR_I = a;
    TOKEN_EP_I = ep;
    TOKEN_CHECK_OK_I = ok;
    TOKEN_VALID_I = 1;
    @(negedge MCLK_I);
    TOKEN_VALID_I = 0;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge MCLK_I);
    @(negedge MCLK_I);
    RST_I = 0;
    check(ctl, 11'h002);
    rw(OFF_SERIAL_LINE_CONTROL, 0, 0);
    check(q, 32'h0000_0002);
    rw(OFF_LAST_ENDPOINT, 0, 0);
    check(q, 0);
    $display("reset test done");
    for (i = 0; i < 10; i++) begin
      rw(rows[i].a, 1, rows[i].d);
      rw(rows[i].a, 0, 0);
      check(q, rows[i].q);
    end
    check(ctl, 11'h7ff);
    rw(OFF_SERIAL_LINE_CONTROL, 1, 32'h0000_0002);
    rw(OFF_FLAG_STICKINESS, 1, 0);
    rw(OFF_ENDPOINT_MARKING, 1, 32'h0000_0008);
    $display("register table test done");
    otg_pins = 6'h2a;
    repeat (6) @(negedge MCLK_I);
    rw(OFF_OTG_STATUS, 0, 0);
    check(q, 32'h0000_002a);
    line_pins = 7'h53;
    repeat (6) @(negedge MCLK_I);
    rw(OFF_SERIAL_LINE_CONTROL, 0, 0);
    check(q, 32'h0000_0052);
    $display("live input test done");
    for (i = 0; i < 3; i++) begin
      line_pins = {5'h00, ls_codes[i]};
      repeat (6) @(negedge MCLK_I);
      rw(OFF_LINE_EVENT_FLAGS, 0, 0);
      check(q[5:3], ls_flags[i]);
    end
    line_pins = 7'h1f;
    repeat (6) @(negedge MCLK_I);
    rw(OFF_LINE_EVENT_FLAGS, 0, 0);
    check(q[5:0], 6'h03);
    line_pins = 7'h02;
    rw(OFF_FLAG_PORT_MASKS, 1, 32'h7f10_0810);
    repeat (6) @(negedge MCLK_I);
    check(fp, 4'hb);
    rw(OFF_FLAG_PORT_MASKS, 1, 0);
    repeat (3) @(negedge MCLK_I);
    check(fp, 4'h0);
    $display("line flag test done");
    pulse(DATA_CRC16_FAIL_I);
    rw(OFF_LINE_EVENT_FLAGS, 0, 0);
    check(q[2], 1'b1);
    pulse(PKT_START_I);
    rw(OFF_LINE_EVENT_FLAGS, 0, 0);
    check(q[2], 1'b0);
    rw(OFF_FLAG_STICKINESS, 1, 32'h0000_0004);
    pulse(DATA_CRC16_FAIL_I);
    pulse(PKT_START_I);
    rw(OFF_LINE_EVENT_FLAGS, 1, 0);
    rw(OFF_LINE_EVENT_FLAGS, 0, 0);
    check(q[2], 1'b1);
    rw(OFF_LINE_EVENT_FLAGS, 1, 32'h0000_0004);
    rw(OFF_LINE_EVENT_FLAGS, 0, 0);
    check(q[2], 1'b0);
    $display("sticky test done");
    rw(OFF_DEV_ADDR, 1, 32'h0000_0005);
    tok(7'h05, 4'h3, 1);
    check({TOKEN_ACCEPT_O, RX_EP_VALID_O, RX_EP_O}, 7'h73);
    rw(OFF_LAST_ENDPOINT, 0, 0);
    check(q, 32'h0000_0013);
    rw(OFF_LINE_EVENT_FLAGS, 0, 0);
    check(q[6], 1'b1);
    tok(7'h06, 4'h2, 1);
    check({TOKEN_ACCEPT_O, RX_EP_VALID_O, RX_EP_O}, 7'h13);
    tok(7'h05, 4'h2, 0);
    check({TOKEN_ACCEPT_O, RX_EP_VALID_O}, 2'h0);
    tok(7'h05, 4'h2, 1);
    check({TOKEN_ACCEPT_O, RX_EP_VALID_O, RX_EP_O}, 7'h62);
    $display("token test done");
    PID_I = 4'ha;
    pulse(PID_VALID_I);
    rw(OFF_LAST_PACKET_ID, 0, 0);
    check(q, 32'h0000_000a);
    SOF_FRAME_I = 11'h5a3;
    pulse(SOF_VALID_I);
    rw(OFF_FRAME_COUNTER, 0, 0);
    check(q, 32'h0000_05a3);
    $display("capture test done");
    // Reset in mid-run must restore the idle transmit enable and clear stickiness
    RST_I = 1;
    @(negedge MCLK_I);
    RST_I = 0;
    check(ctl, 11'h002);
    rw(OFF_FLAG_STICKINESS, 0, 0);
    check(q, 0);
    rw(OFF_SERIAL_LINE_CONTROL, 0, 0);
    check(q[3:0], 4'h2);
    $display("mid-run reset test done");
    test_done();
  end
endmodule
